// ===== hw/pint_engine.sv
// Pin interrupt and pattern match engine with APB register slave.
// Assumes pins, power mode and APB are synchronous to clk_in except pins_in,
// which are synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Eight channels each pick any of the port pins and own one request line.
// - Edge channels request on rising, falling or both edges as configured.
// - Level channels request while the pin sits at the programmed active level.
// - Any pin request unmasked in mask raises wake-up in sleep, deep sleep or power down.
// - In pattern mode the eight selected pins feed a boolean expression.
// - Each slice tests a level or a transition; slices chain into product terms.
// - Each slice that ends a product term drives its own request when satisfied.
// - When enabled, any pattern match emits a cpu event notification.
// - The event notification can be routed out to a device pin.
// - Pattern match wakes the device only in active or sleep mode.
// - Pin choice is a system config selection, independent of pin muxing.
// - Registers answer every APB access in a single cycle, no wait state.
module pint_engine #(
  parameter int unsigned NUM_PINS = 50
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [7:0]            paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  input  wire logic [NUM_PINS-1:0]   pins_in,
  input  wire logic [1:0]            power_mode_in,
  output logic      [7:0]            irq_out,
  output logic                       irq_any_out,
  output logic                       cpu_event_notify_out,
  output logic                       event_pin_out,
  output logic                       wake_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] field8(input logic [31:0] w, input int unsigned i);
    field8 = w[(i%4)*8 +: 8];
  endfunction : field8

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  pint_pkg::pint_cfg_s cfg;
  logic [7:0]          status;
  logic [7:0]          sel_raw;
  logic [7:0]          sync1;
  logic [7:0]          sync2;
  logic [7:0]          prev;
  logic [7:0]          rise;
  logic [7:0]          fall;
  logic [7:0]          pin_event;
  logic [7:0]          level_req;
  logic [7:0]          sticky_r;
  logic [7:0]          sticky_f;
  logic [7:0]          slice_true;
  logic [7:0]          term_match;
  logic [7:0]          next_status;
  logic                pm_mode;
  logic                wr_en;
  logic                rd_en;
  logic                mapped;
  logic                pm_wake;
  pint_pkg::pint_pwr_e pwr;

  assign pm_mode = cfg.pmctrl[pint_pkg::PMCTRL_SEL_BIT];
  assign wr_en   = psel_in && penable_in && pwrite_in;
  assign rd_en   = psel_in && !penable_in && !pwrite_in;
  assign pwr     = pint_pkg::pint_pwr_e'(power_mode_in);

  // ----------------------------------------------------------------
  // Pin selection and synchronisation
  // ----------------------------------------------------------------
  // Selection reads the raw pad level, so pin muxing has no say.
  for (genvar c = 0; c < 8; c++) begin : g_sel
    logic [7:0] idx;
    assign idx = field8(c < 4 ? cfg.pinsel0 : cfg.pinsel1, c);
    assign sel_raw[c] = (idx < NUM_PINS) ? pins_in[idx[5:0]] : 1'b0;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      prev  <= 8'h00;
    end else begin
      sync1 <= sel_raw;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign rise = sync2 & ~prev;
  assign fall = ~sync2 & prev;

  // ----------------------------------------------------------------
  // Pin interrupt detection
  // ----------------------------------------------------------------
  // Level channel: enrise enables, enfall picks high (1) or low (0).
  assign pin_event = (~cfg.mode[7:0] & ((rise & cfg.enrise[7:0])
                                       | (fall & cfg.enfall[7:0])));
  assign level_req = cfg.mode[7:0] & cfg.enrise[7:0]
                     & ~(sync2 ^ cfg.enfall[7:0]);

  // ----------------------------------------------------------------
  // Pattern match slices
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sticky_r <= 8'h00;
      sticky_f <= 8'h00;
    end else begin
      for (int s = 0; s < 8; s++) begin
        logic [2:0] src;
        src = cfg.pmsrc[s*3 +: 3];
        if (!pm_mode) begin
          sticky_r[s] <= 1'b0;
          sticky_f[s] <= 1'b0;
        end else begin
          sticky_r[s] <= sticky_r[s] | rise[src];
          sticky_f[s] <= sticky_f[s] | fall[src];
        end
      end
    end
  end

  for (genvar s = 0; s < 8; s++) begin : g_slice
    logic [2:0] src;
    logic [2:0] cond;
    logic       lvl;
    logic       any_edge;
    assign src      = cfg.pmsrc[s*3 +: 3];
    assign cond     = cfg.pmcfg[s*3 +: 3];
    assign lvl      = sync2[src];
    logic       hit;
    assign any_edge = rise[src] | fall[src];
    // Local result, so each slice process writes only its own variable
    always_comb begin
      case (pint_pkg::pint_cond_e'(cond))
        pint_pkg::PM_CONST_HIGH:  hit = 1'b1;
        pint_pkg::PM_STICKY_RISE: hit = sticky_r[s] | rise[src];
        pint_pkg::PM_STICKY_FALL: hit = sticky_f[s] | fall[src];
        pint_pkg::PM_STICKY_EDGE: hit = sticky_r[s] | sticky_f[s] | any_edge;
        pint_pkg::PM_LEVEL_HIGH:  hit = lvl;
        pint_pkg::PM_LEVEL_LOW:   hit = !lvl;
        pint_pkg::PM_CONST_LOW:   hit = 1'b0;
        pint_pkg::PM_EVENT_EDGE:  hit = any_edge;
        default:                  hit = 1'b0;
      endcase
    end
    assign slice_true[s] = hit;
  end

  // A product term spans from after the previous end slice up to this one.
  always_comb begin
    logic acc;
    acc = 1'b1;
    term_match = 8'h00;
    for (int s = 0; s < 8; s++) begin
      acc = acc & slice_true[s];
      if (cfg.pmend[s]) begin
        term_match[s] = acc & pm_mode;
        acc = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupts
  // ----------------------------------------------------------------
  // Set wins over a write-one-clear in the same cycle.
  always_comb begin
    next_status = status;
    if (wr_en && addr_hit(paddr_in, pint_pkg::OFS_STATUS)) begin
      next_status = next_status & ~pwdata_in[7:0];
    end
    if (pm_mode) begin
      next_status = next_status | term_match;
    end else begin
      next_status = next_status | pin_event | level_req;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status <= 8'h00;
    end else begin
      status <= next_status;
    end
  end

  assign pm_wake = (pwr == pint_pkg::PWR_ACTIVE) || (pwr == pint_pkg::PWR_SLEEP);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out              <= 8'h00;
      irq_any_out          <= 1'b0;
      cpu_event_notify_out <= 1'b0;
      event_pin_out        <= 1'b0;
      wake_out             <= 1'b0;
    end else begin
      irq_out     <= next_status & cfg.mask[7:0];
      irq_any_out <= |(next_status & cfg.mask[7:0]);
      cpu_event_notify_out <= cfg.pmctrl[pint_pkg::PMCTRL_EV_BIT] && |term_match;
      event_pin_out <= cfg.pmctrl[pint_pkg::PMCTRL_PIN_BIT]
                       && cfg.pmctrl[pint_pkg::PMCTRL_EV_BIT] && |term_match;
      if (pm_mode) begin
        wake_out <= pm_wake && |(next_status & cfg.mask[7:0]);
      end else begin
        wake_out <= |(next_status & cfg.mask[7:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg       <= '0;
      cfg.pmend <= {24'h00_0000, pint_pkg::RST_PMEND};
    end else if (wr_en) begin
      case (paddr_in)
        pint_pkg::OFS_MODE:    cfg.mode    <= {24'h00_0000, pwdata_in[7:0]};
        pint_pkg::OFS_ENRISE:  cfg.enrise  <= {24'h00_0000, pwdata_in[7:0]};
        pint_pkg::OFS_ENFALL:  cfg.enfall  <= {24'h00_0000, pwdata_in[7:0]};
        pint_pkg::OFS_MASK:    cfg.mask    <= {24'h00_0000, pwdata_in[7:0]};
        pint_pkg::OFS_PMCTRL:  cfg.pmctrl  <= {29'h0000_0000, pwdata_in[2:0]};
        pint_pkg::OFS_PMSRC:   cfg.pmsrc   <= {8'h00, pwdata_in[23:0]};
        pint_pkg::OFS_PMCFG:   cfg.pmcfg   <= {8'h00, pwdata_in[23:0]};
        pint_pkg::OFS_PMEND:   cfg.pmend   <= {24'h00_0000, pwdata_in[7:0]};
        pint_pkg::OFS_PINSEL0: cfg.pinsel0 <= pwdata_in;
        pint_pkg::OFS_PINSEL1: cfg.pinsel1 <= pwdata_in;
        default:               cfg.mode    <= cfg.mode;
      endcase
    end
  end

  assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in <= pint_pkg::OFS_POWER);

  // Read data captured in setup so the access phase ends in one cycle.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !mapped;
      if (rd_en) begin
        case (paddr_in)
          pint_pkg::OFS_MODE:    prdata_out <= cfg.mode;
          pint_pkg::OFS_ENRISE:  prdata_out <= cfg.enrise;
          pint_pkg::OFS_ENFALL:  prdata_out <= cfg.enfall;
          pint_pkg::OFS_STATUS:  prdata_out <= {24'h00_0000, status};
          pint_pkg::OFS_MASK:    prdata_out <= cfg.mask;
          pint_pkg::OFS_PMCTRL:  prdata_out <= cfg.pmctrl;
          pint_pkg::OFS_PMSRC:   prdata_out <= cfg.pmsrc;
          pint_pkg::OFS_PMCFG:   prdata_out <= cfg.pmcfg;
          pint_pkg::OFS_PMEND:   prdata_out <= cfg.pmend;
          pint_pkg::OFS_PINSEL0: prdata_out <= cfg.pinsel0;
          pint_pkg::OFS_PINSEL1: prdata_out <= cfg.pinsel1;
          pint_pkg::OFS_PINS:    prdata_out <= {24'h00_0000, sync2};
          pint_pkg::OFS_POWER:   prdata_out <= {30'h0000_0000, power_mode_in};
          default:               prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_apb_single_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
    psel_in && !penable_in |=> pready_out)
    else $error("APB access not answered in one cycle");

  a_sync_two_stage: assert property (@(posedge clk_in) disable iff (rst_in)
    sync2 == $past(sel_raw, 2) || $past(rst_in, 2))
    else $error("Pin synchroniser is not two stages");

  a_rise_sets_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    !pm_mode && !cfg.mode[0] && cfg.enrise[0] && rise[0] |=> status[0])
    else $error("Rising edge did not set channel zero");

  a_level_holds_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    !pm_mode && level_req[0] |=> status[0])
    else $error("Active level did not hold channel zero");

  a_irq_follows: assert property (@(posedge clk_in) disable iff (rst_in)
    irq_out == (status & cfg.mask[7:0]) || $changed(status) || $changed(cfg.mask))
    else $error("Interrupt line disagrees with status and mask");

  a_wake_pin_mode: assert property (@(posedge clk_in) disable iff (rst_in)
    !pm_mode && |(next_status & cfg.mask[7:0]) |=> wake_out)
    else $error("Pin interrupt did not wake");

  a_no_deep_wake: assert property (@(posedge clk_in) disable iff (rst_in)
    pm_mode && !pm_wake |=> !wake_out)
    else $error("Pattern match woke from deep mode");

  a_event_notify: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg.pmctrl[pint_pkg::PMCTRL_EV_BIT] && |term_match |=> cpu_event_notify_out)
    else $error("Pattern match gave no event");

  a_event_pin: assert property (@(posedge clk_in) disable iff (rst_in)
    event_pin_out |-> cpu_event_notify_out)
    else $error("Event pin without event");

  a_term_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    |term_match |=> (status & $past(term_match)) == $past(term_match))
    else $error("Product term did not set its flag");

  a_edge_sets_all: assert property (@(posedge clk_in) disable iff (rst_in)
    !pm_mode && |pin_event |=> (status & $past(pin_event)) == $past(pin_event))
    else $error("Edge event did not set its channel flag");

  a_level_sets_all: assert property (@(posedge clk_in) disable iff (rst_in)
    !pm_mode && |level_req |=> (status & $past(level_req)) == $past(level_req))
    else $error("Active level did not set its channel flag");

  a_unmapped_err: assert property (@(posedge clk_in) disable iff (rst_in)
    psel_in && !penable_in && !mapped |=> pslverr_out)
    else $error("Unmapped access gave no slave error");

  a_event_pin_on: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg.pmctrl[pint_pkg::PMCTRL_PIN_BIT] && cfg.pmctrl[pint_pkg::PMCTRL_EV_BIT]
    && |term_match |=> event_pin_out)
    else $error("Routed event did not reach the pin");

  a_no_idle_wake: assert property (@(posedge clk_in) disable iff (rst_in)
    !(|(next_status & cfg.mask[7:0])) |=> !wake_out)
    else $error("Wake raised with no masked request");

  // Sticky edge memory must not survive a return to pin mode
  a_sticky_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
    !pm_mode |=> sticky_r == 8'h00 && sticky_f == 8'h00)
    else $error("Sticky slice edges kept outside pattern mode");

endmodule : pint_engine

`default_nettype wire

// ===== hw/pint_pkg.sv
// Package for the pin interrupt and pattern match engine.
// Assumes a single 100 MHz clock domain and an APB register slave.
package pint_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH     = 8;
  localparam int unsigned PIN_SEL_W  = 6;
  localparam int unsigned ADDR_W     = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MODE    = 8'h00;  // 1 = level, 0 = edge
  localparam logic [7:0] OFS_ENRISE  = 8'h04;  // Rise enable / level enable
  localparam logic [7:0] OFS_ENFALL  = 8'h08;  // Fall enable / active high
  localparam logic [7:0] OFS_STATUS  = 8'h0C;  // Sticky, write one to clear
  localparam logic [7:0] OFS_MASK    = 8'h10;
  localparam logic [7:0] OFS_PMCTRL  = 8'h14;
  localparam logic [7:0] OFS_PMSRC   = 8'h18;  // 3 bits of input per slice
  localparam logic [7:0] OFS_PMCFG   = 8'h1C;  // 3-bit condition per slice
  localparam logic [7:0] OFS_PMEND   = 8'h20;  // Slice ends a product term
  localparam logic [7:0] OFS_PINSEL0 = 8'h24;  // Channels 0..3, byte each
  localparam logic [7:0] OFS_PINSEL1 = 8'h28;  // Channels 4..7
  localparam logic [7:0] OFS_PINS    = 8'h2C;  // Synchronised channel levels
  localparam logic [7:0] OFS_POWER   = 8'h30;  // Current power mode, read only

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PMCTRL_SEL_BIT  = 0;  // 1 = pattern match mode
  localparam int unsigned PMCTRL_EV_BIT   = 1;  // Event notify enable
  localparam int unsigned PMCTRL_PIN_BIT  = 2;  // Route event to pin
  localparam int unsigned PMSRC_W         = 3;
  localparam int unsigned PMCFG_W         = 3;
  localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
  localparam logic [7:0]  RST_PMEND       = 8'h80;  // Slice 7 ends by default
  localparam int unsigned EVENT_PULSE_CYC = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PM_CONST_HIGH,
    PM_STICKY_RISE,
    PM_STICKY_FALL,
    PM_STICKY_EDGE,
    PM_LEVEL_HIGH,
    PM_LEVEL_LOW,
    PM_CONST_LOW,
    PM_EVENT_EDGE
  } pint_cond_e;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_SLEEP,
    PWR_DEEP_SLEEP,
    PWR_POWER_DOWN
  } pint_pwr_e;

  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] enrise;
    logic [31:0] enfall;
    logic [31:0] mask;
    logic [31:0] pmctrl;
    logic [31:0] pmsrc;
    logic [31:0] pmcfg;
    logic [31:0] pmend;
    logic [31:0] pinsel0;
    logic [31:0] pinsel1;
  } pint_cfg_s;

endpackage : pint_pkg

// ===== bench/pint_pin_model.sv
// Behavioural model of the selected device pins on the far side of the engine.
// Assumes the bench calls set_pin hierarchically; levels change at a rising edge.
`timescale 1ns/1ps
`default_nettype none

module pint_pin_model #(
  parameter int unsigned NUM_PINS = 50
) (
  input  wire logic                clk_in,
  output logic      [NUM_PINS-1:0] pins_out
);
  // ----------------------------------------------------------------
  // Pad levels
  // ----------------------------------------------------------------
  // Pads are always driven, so no floating value is modelled
  initial pins_out = '0;

  task automatic set_pin(input int unsigned idx, input logic lvl);
    @(posedge clk_in);
    pins_out[idx] <= lvl;
  endtask : set_pin
endmodule : pint_pin_model

`default_nettype wire

// ===== bench/pint_engine_tb.sv
// Self-checking bench for the pin interrupt and pattern match engine.
// Assumes the wait-free APB slave of the engine and pint_pin_model.
`timescale 1ns/1ps
`default_nettype none

module pint_engine_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [49:0] pins;
  logic [1:0]  power_mode_in = 2'h0;
  logic [7:0]  irq_out;
  logic        irq_any_out;
  logic        cpu_event_notify_out;
  logic        event_pin_out;
  logic        wake_out;
  logic [31:0] q;
  logic        e;
  int          errors = 0;
  int          checked = 0;

  always #5 clk_in = ~clk_in;

  pint_pin_model #(.NUM_PINS(50)) pm_u (.clk_in(clk_in), .pins_out(pins));

  pint_engine #(.NUM_PINS(50)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .pins_in(pins), .power_mode_in(power_mode_in), .irq_out(irq_out),
    .irq_any_out(irq_any_out), .cpu_event_notify_out(cpu_event_notify_out),
    .event_pin_out(event_pin_out), .wake_out(wake_out));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    chk("pready_wait", 32'h1, 32'(n));
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, q);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  task automatic tally_and_finish;
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // About 220 cycles of tests; ample margin before calling it a hang
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tick(10);
    rst_in <= 1'b0;
    rd(pint_pkg::OFS_PMEND, 32'h0000_0080, "pmend_rst");
    rd(pint_pkg::OFS_MASK, 32'h0000_0000, "mask_rst");
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk("unmapped_err", 32'h1, 32'(e));
    pm_u.set_pin(0, 1'b1);
    // Ch0..3 on pins 5,40,49,12; ch4..7 on pins 0..3
    apb(1'b1, pint_pkg::OFS_PINSEL0, 32'h0C31_2805);
    apb(1'b1, pint_pkg::OFS_PINSEL1, 32'h0302_0100);
    rd(pint_pkg::OFS_PINSEL0, 32'h0C31_2805, "pinsel0");
    apb(1'b1, pint_pkg::OFS_MODE, 32'h0000_0018);
    apb(1'b1, pint_pkg::OFS_ENRISE, 32'h0000_001D);
    apb(1'b1, pint_pkg::OFS_ENFALL, 32'h0000_000E);
    apb(1'b1, pint_pkg::OFS_MASK, 32'h0000_00FF);
    tick(6);
    apb(1'b1, pint_pkg::OFS_STATUS, 32'h0000_00FF);
    rd(pint_pkg::OFS_STATUS, 32'h0000_0000, "status_idle");
    pm_u.set_pin(5, 1'b1);
    pm_u.set_pin(49, 1'b1);
    tick(6);
    rd(pint_pkg::OFS_STATUS, 32'h0000_0005, "status_rise");
    chk("irq_rise", 32'h05, 32'(irq_out));
    chk("irq_any", 32'h1, 32'(irq_any_out));
    apb(1'b1, pint_pkg::OFS_STATUS, 32'h0000_0005);
    pm_u.set_pin(5, 1'b0);
    pm_u.set_pin(49, 1'b0);
    pm_u.set_pin(40, 1'b1);
    tick(6);
    rd(pint_pkg::OFS_STATUS, 32'h0000_0004, "status_fall");
    pm_u.set_pin(40, 1'b0);
    tick(6);
    rd(pint_pkg::OFS_STATUS, 32'h0000_0006, "status_fall2");
    apb(1'b1, pint_pkg::OFS_STATUS, 32'h0000_0006);
    tick(2);
    chk("irq_clear", 32'h00, 32'(irq_out));
    apb(1'b1, pint_pkg::OFS_MASK, 32'h0000_00FB);
    pm_u.set_pin(49, 1'b1);
    tick(6);
    chk("irq_masked", 32'h00, 32'(irq_out));
    apb(1'b1, pint_pkg::OFS_STATUS, 32'h0000_0004);
    apb(1'b1, pint_pkg::OFS_MASK, 32'h0000_00FF);
    pm_u.set_pin(12, 1'b1);
    tick(6);
    apb(1'b1, pint_pkg::OFS_STATUS, 32'h0000_0008);
    tick(2);
    rd(pint_pkg::OFS_STATUS, 32'h0000_0008, "level_hold");
    pm_u.set_pin(12, 1'b0);
    tick(6);
    apb(1'b1, pint_pkg::OFS_STATUS, 32'h0000_0008);
    rd(pint_pkg::OFS_STATUS, 32'h0000_0000, "level_gone");
    pm_u.set_pin(0, 1'b0);
    tick(6);
    chk("irq_low_act", 32'h10, 32'(irq_out));
    for (int m = 1; m < 4; m++) begin
      power_mode_in <= 2'(m);
      tick(3);
      chk("pin_wake", 32'h1, 32'(wake_out));
    end
    rd(pint_pkg::OFS_PINS, 32'h0000_0004, "synced_pins");
    pm_u.set_pin(0, 1'b1);
    power_mode_in <= pint_pkg::PWR_SLEEP;
    apb(1'b1, pint_pkg::OFS_MASK, 32'h0000_0001);
    tick(6);
    apb(1'b1, pint_pkg::OFS_STATUS, 32'h0000_00FF);
    // Slice 0 tests ch1 high and ends the term; other slices constant low
    apb(1'b1, pint_pkg::OFS_PMSRC, 32'h0000_0001);
    apb(1'b1, pint_pkg::OFS_PMCFG, 32'h00DB_6DB4);
    apb(1'b1, pint_pkg::OFS_PMEND, 32'h0000_0001);
    apb(1'b1, pint_pkg::OFS_PMCTRL, 32'h0000_0003);
    tick(6);
    chk("no_match", 32'h0, 32'(cpu_event_notify_out));
    pm_u.set_pin(40, 1'b1);
    tick(6);
    chk("ev_match", 32'h1, 32'(cpu_event_notify_out));
    chk("ev_pin_off", 32'h0, 32'(event_pin_out));
    chk("pm_wake_slp", 32'h1, 32'(wake_out));
    rd(pint_pkg::OFS_STATUS, 32'h0000_0001, "term_flag");
    apb(1'b1, pint_pkg::OFS_PMCTRL, 32'h0000_0007);
    apb(1'b1, pint_pkg::OFS_MASK, 32'h0000_0001);
    tick(3);
    chk("ev_pin_on", 32'h1, 32'(event_pin_out));
    chk("term_irq", 32'h01, 32'(irq_out));
    power_mode_in <= pint_pkg::PWR_DEEP_SLEEP;
    tick(3);
    chk("pm_wake_deep", 32'h0, 32'(wake_out));
    rd(pint_pkg::OFS_POWER, 32'h0000_0002, "power_rd");
    apb(1'b1, pint_pkg::OFS_PMCTRL, 32'h0000_0005);
    tick(3);
    chk("ev_disabled", 32'h0, 32'(cpu_event_notify_out));
    tally_and_finish();
  end
endmodule : pint_engine_tb

`default_nettype wire
